// ---- src/nsr_top.sv ----
// Setup register bank with Wishbone slave, rate dividers, timers and interrupts.
`timescale 1ns/10ps

// Functional notes
// R01 - Line pulse push-pull when set, else open-drain.
// R02 - Excess refusal flag after four or 128.
// R03 - Promiscuous mode accepts every valid packet.
// R04 - Acknowledge only packets matching own node.
// R05 - Promiscuous plus disabled transmitter gives listen-only.
// R06 - Prescaler code selects data rate divisor.
// R07 - RAM init waits idle line unless skipped.
// R08 - Reconfiguration timeout selected by two bits.
// R09 - Arbitration clock halved when bit set.
// R10 - Fast read timing bit, writes unaffected.
// R11 - Extended features bit, reset selects legacy.
module nsr_top #(
  parameter int MS_CYC = nsr_pkg::MS_CYC  // Cycles per millisecond.
) (
  input  wire logic        clk_i,          // System clock, 50 MHz.
  input  wire logic        rst_i,          // Synchronous reset, active high.
  input  wire logic        wb_cyc_i,       // Bus cycle.
  input  wire logic        wb_stb_i,       // Bus strobe.
  input  wire logic        wb_we_i,        // Write enable.
  input  wire logic [7:0]  wb_adr_i,       // Byte address.
  input  wire logic [3:0]  wb_sel_i,       // Byte lane selects.
  input  wire logic [31:0] wb_dat_i,       // Write data.
  output logic      [31:0] wb_dat_o,       // Read data.
  output logic             wb_ack_o,       // Acknowledge.
  output logic             irq_o,          // Level interrupt.
  input  wire logic        pulse_data_i,   // Line pulse level from engine.
  output logic             line_pulse_out_o, // Line pulse output value.
  output logic             line_pulse_oe_n_o, // Line pulse enable, low drives.
  input  wire logic        refusal_i,      // One refused buffer enquiry.
  output logic             excess_refusal_flag_o, // Excess refusal flag.
  input  wire logic        pkt_valid_i,    // Valid packet header pulse.
  input  wire logic [7:0]  pkt_dest_i,     // Packet destination ID.
  input  wire logic [7:0]  node_id_i,      // Own programmed node ID.
  input  wire logic        tx_enable_i,    // Transmitter enabled.
  output logic             pkt_accept_o,   // Packet is to be stored.
  output logic             pkt_ack_o,      // Packet is to be acknowledged.
  output logic             token_pass_o,   // Node takes part in token passing.
  output logic             listen_only_o,  // Listen-only monitor active.
  output logic             rate_tick_o,    // Bit rate enable pulse.
  output logic             arb_tick_o,     // Arbitration enable pulse.
  input  wire logic        init_req_i,     // Request RAM initialization.
  input  wire logic        line_idle_i,    // Line idle pin, asynchronous.
  output logic             init_start_o,   // RAM initialization start pulse.
  input  wire logic        recon_restart_i, // Restart reconfiguration timer.
  output logic             recon_timeout_o, // Reconfiguration timeout pulse.
  output logic             fast_read_timing_o, // Fast host read timing.
  output logic             extended_features_o  // Extended functions on.
);
  // Refuse settings the counters cannot serve, at elaboration.
  if (MS_CYC < 2 || MS_CYC > 65535)
  begin : g_bad_ms_cyc
    $error("MS_CYC out of range");
  end

  // Init state machine codes.
  typedef enum logic [1:0] {
    NSR_IDLE = 2'b01,
    NSR_WAIT = 2'b10
  } nsr_init_e;

  // Timeout in milliseconds for a reconfiguration code.
  function automatic logic [12:0] nsr_recon_ms(input logic [1:0] code);
    unique case (code)
      2'b00:   nsr_recon_ms = 13'(nsr_pkg::RECON_MS_0);
      2'b01:   nsr_recon_ms = 13'(nsr_pkg::RECON_MS_1);
      2'b10:   nsr_recon_ms = 13'(nsr_pkg::RECON_MS_2);
      default: nsr_recon_ms = 13'(nsr_pkg::RECON_MS_3);
    endcase
  endfunction

  logic [7:0]  setup1_q, setup1_d;        // First setup register.
  logic [7:0]  setup2_q, setup2_d;        // Second setup register.
  logic [2:0]  stat_q, stat_d;            // Sticky interrupt status.
  logic [2:0]  mask_q, mask_d;            // Interrupt mask.
  logic        ack_q, ack_d;              // Bus acknowledge.
  logic [31:0] rdat_q, rdat_d;            // Read data.
  logic        irq_q, irq_d;              // Interrupt output.
  logic [7:0]  ref_cnt_q, ref_cnt_d;      // Refusal counter.
  logic        lp_out_q, lp_out_d;        // Line pulse value.
  logic        lp_oen_q, lp_oen_d;        // Line pulse enable.
  logic        acc_q, acc_d;              // Accept pulse.
  logic        pack_q, pack_d;            // Ack pulse.
  logic        tok_q, tok_d;              // Token participation.
  logic        lst_q, lst_d;              // Listen-only.
  logic [10:0] rate_cnt_q, rate_cnt_d;    // Rate divider.
  logic        rate_q, rate_d;            // Rate tick.
  logic        arb_ph_q, arb_ph_d;        // Arbitration phase.
  logic        idle_s1_q, idle_s2_q;      // Idle pin synchroniser.
  nsr_init_e   init_q, init_d;            // Init state.
  logic        istart_q, istart_d;        // Init start pulse.
  logic [15:0] ms_cnt_q, ms_cnt_d;        // Millisecond prescaler.
  logic [12:0] rc_cnt_q, rc_cnt_d;        // Reconfiguration ms counter.
  logic        rto_q, rto_d;              // Timeout pulse.
  logic        wr_en;                     // Write takes effect now.
  logic        rd_req;                    // New read request.
  logic [2:0]  ev;                        // Events this cycle.
  logic [7:0]  limit;                     // Selected refusal limit.

  // The write happens at the edge where the master sees ack.
  assign wr_en  = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign rd_req = wb_cyc_i && wb_stb_i && !ack_q;

  // Bus slave, setup registers, interrupt status and mask.
  always_comb
  begin
    setup1_d = setup1_q;
    setup2_d = setup2_q;
    mask_d   = mask_q;
    stat_d   = stat_q;
    ack_d    = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d   = rdat_q;
    if (rd_req)
    begin
      // Unmapped addresses read zero and are still acknowledged.
      unique case (wb_adr_i)
        nsr_pkg::ADDR_SETUP1: rdat_d = {24'h000000, setup1_q};
        nsr_pkg::ADDR_SETUP2: rdat_d = {24'h000000, setup2_q};
        nsr_pkg::ADDR_STATUS: rdat_d = {29'h0000000, stat_q};
        nsr_pkg::ADDR_MASK:   rdat_d = {29'h0000000, mask_q};
        nsr_pkg::ADDR_STATE:  rdat_d = {24'h000000, ref_cnt_q};
        default:              rdat_d = 32'h00000000;
      endcase
    end
    if (wr_en && wb_sel_i[0])
    begin
      unique case (wb_adr_i)
        nsr_pkg::ADDR_SETUP1: setup1_d = wb_dat_i[7:0] & nsr_pkg::S1_WMASK;
        nsr_pkg::ADDR_SETUP2: setup2_d = wb_dat_i[7:0] & nsr_pkg::S2_WMASK;
        nsr_pkg::ADDR_STATUS: stat_d   = stat_q & ~wb_dat_i[2:0];
        nsr_pkg::ADDR_MASK:   mask_d   = wb_dat_i[2:0];
        default:              mask_d   = mask_q;
      endcase
    end
    // Hardware events win over a simultaneous clear.
    stat_d = stat_d | ev;
    irq_d  = |(stat_d & mask_d);
  end

  // Register the bus and control state.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      setup1_q <= nsr_pkg::S1_RESET;
      setup2_q <= nsr_pkg::S2_RESET;
      stat_q   <= 3'h0;
      mask_q   <= 3'h0;
      ack_q    <= 1'b0;
      rdat_q   <= 32'h00000000;
      irq_q    <= 1'b0;
    end
    else
    begin
      setup1_q <= setup1_d;
      setup2_q <= setup2_d;
      stat_q   <= stat_d;
      mask_q   <= mask_d;
      ack_q    <= ack_d;
      rdat_q   <= rdat_d;
      irq_q    <= irq_d;
    end
  end

  // Refusal counting, packet filter and line driver selection.
  always_comb
  begin
    // R02 refusal limit select
    limit = setup1_q[nsr_pkg::S1_LIM_SEL] ? nsr_pkg::LIMIT_SHORT : nsr_pkg::LIMIT_LONG;
    ref_cnt_d = ref_cnt_q;
    ev = 3'h0;
    // The count restarts at a clear; a refusal in that very cycle is not lost.
    if (wr_en && wb_sel_i[0] && wb_adr_i == nsr_pkg::ADDR_STATUS
        && wb_dat_i[nsr_pkg::IRQ_EXCESS])
    begin
      ref_cnt_d = {7'h00, refusal_i};
    end
    else if (refusal_i && ref_cnt_q < limit)
    begin
      ref_cnt_d = ref_cnt_q + 8'h01;
      ev[nsr_pkg::IRQ_EXCESS] = (ref_cnt_q + 8'h01) == limit;
    end
    ev[nsr_pkg::IRQ_RECONF] = rto_d;
    ev[nsr_pkg::IRQ_INIT]   = istart_d;
    // R03 accept any destination
    acc_d  = pkt_valid_i && (setup1_q[nsr_pkg::S1_PROMISC] || pkt_dest_i == node_id_i);
    // R04 ack own ID only
    pack_d = pkt_valid_i && pkt_dest_i == node_id_i;
    // R05 listen-only monitor
    tok_d  = tx_enable_i;
    lst_d  = setup1_q[nsr_pkg::S1_PROMISC] && !tx_enable_i;
    // R01 push-pull or open-drain
    lp_out_d = setup1_q[nsr_pkg::S1_DRV_TYPE] ? pulse_data_i : 1'b0;
    lp_oen_d = setup1_q[nsr_pkg::S1_DRV_TYPE] ? 1'b0 : pulse_data_i;
  end

  // Register refusal count, filter and line driver.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_cnt_q <= 8'h00;
      acc_q     <= 1'b0;
      pack_q    <= 1'b0;
      tok_q     <= 1'b0;
      lst_q     <= 1'b0;
      lp_out_q  <= 1'b0;
      lp_oen_q  <= 1'b1;
    end
    else
    begin
      ref_cnt_q <= ref_cnt_d;
      acc_q     <= acc_d;
      pack_q    <= pack_d;
      tok_q     <= tok_d;
      lst_q     <= lst_d;
      lp_out_q  <= lp_out_d;
      lp_oen_q  <= lp_oen_d;
    end
  end

  // Rate and arbitration enables.
  always_comb
  begin
    // R06 divisor from prescaler
    rate_d     = rate_cnt_q >= 11'(((nsr_pkg::RATE_BASE
                 << setup1_q[nsr_pkg::S1_RATE_LSB +: 3]) - 1) & 16'h07FF);
    rate_cnt_d = rate_d ? 11'h000 : rate_cnt_q + 11'h001;
    // R09 halve arbitration clock
    arb_ph_d   = setup1_q[nsr_pkg::S1_ARB_HALF] ? !arb_ph_q : 1'b1;
  end

  // Register the dividers.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rate_cnt_q <= 11'h000;
      rate_q     <= 1'b0;
      arb_ph_q   <= 1'b0;
    end
    else
    begin
      rate_cnt_q <= rate_cnt_d;
      rate_q     <= rate_d;
      arb_ph_q   <= arb_ph_d;
    end
  end

  // Init sequencing and reconfiguration timer.
  always_comb
  begin
    init_d   = init_q;
    istart_d = 1'b0;
    unique case (init_q)
      NSR_IDLE: init_d = init_req_i ? NSR_WAIT : NSR_IDLE;
      NSR_WAIT:
      begin
        // R07 wait for idle line
        if (idle_s2_q || setup2_q[nsr_pkg::S2_SKIP_IDL])
        begin
          init_d   = NSR_IDLE;
          istart_d = 1'b1;
        end
      end
      default:  init_d = NSR_IDLE;
    endcase
    ms_cnt_d = (ms_cnt_q == 16'(MS_CYC - 1) || recon_restart_i) ? 16'h0000
               : ms_cnt_q + 16'h0001;
    rc_cnt_d = rc_cnt_q;
    rto_d    = 1'b0;
    // R08 selectable reconfiguration timeout
    if (recon_restart_i)
    begin
      rc_cnt_d = 13'h0000;
    end
    else if (ms_cnt_q == 16'(MS_CYC - 1))
    begin
      if (rc_cnt_q + 13'h0001 >= nsr_recon_ms(setup2_q[nsr_pkg::S2_RCN_LSB +: 2]))
      begin
        rc_cnt_d = 13'h0000;
        rto_d    = 1'b1;
      end
      else
      begin
        rc_cnt_d = rc_cnt_q + 13'h0001;
      end
    end
  end

  // Register init state, timers and the idle synchroniser.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      idle_s1_q <= 1'b0;
      idle_s2_q <= 1'b0;
      init_q    <= NSR_IDLE;
      istart_q  <= 1'b0;
      ms_cnt_q  <= 16'h0000;
      rc_cnt_q  <= 13'h0000;
      rto_q     <= 1'b0;
    end
    else
    begin
      idle_s1_q <= line_idle_i;
      idle_s2_q <= idle_s1_q;
      init_q    <= init_d;
      istart_q  <= istart_d;
      ms_cnt_q  <= ms_cnt_d;
      rc_cnt_q  <= rc_cnt_d;
      rto_q     <= rto_d;
    end
  end

  // Outputs straight from flip-flops.
  assign wb_dat_o              = rdat_q;
  assign wb_ack_o              = ack_q;
  assign irq_o                 = irq_q;
  assign line_pulse_out_o      = lp_out_q;
  assign line_pulse_oe_n_o     = lp_oen_q;
  assign excess_refusal_flag_o = stat_q[nsr_pkg::IRQ_EXCESS];
  assign pkt_accept_o          = acc_q;
  assign pkt_ack_o             = pack_q;
  assign token_pass_o          = tok_q;
  assign listen_only_o         = lst_q;
  assign rate_tick_o           = rate_q;
  assign arb_tick_o            = arb_ph_q;
  assign init_start_o          = istart_q;
  assign recon_timeout_o       = rto_q;
  // R10 fast read timing
  assign fast_read_timing_o    = setup2_q[nsr_pkg::S2_FAST_RD];
  // R11 extended features
  assign extended_features_o   = setup2_q[nsr_pkg::S2_EXT_FEAT];
endmodule

// ---- common/nsr_pkg.sv ----
// Package with register map, reset values and timing constants of the setup registers.
package nsr_pkg;
  // Byte addresses of the word registers on the bus.
  localparam logic [7:0] ADDR_SETUP1 = 8'h00;
  localparam logic [7:0] ADDR_SETUP2 = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0C;
  localparam logic [7:0] ADDR_STATE  = 8'h10;
  // Field positions of the first setup register.
  localparam int S1_DRV_TYPE = 7;
  localparam int S1_LIM_SEL  = 6;
  localparam int S1_PROMISC  = 4;
  localparam int S1_RATE_LSB = 1;
  localparam int S1_ARB_HALF = 0;
  // Field positions of the second setup register.
  localparam int S2_FAST_RD  = 7;
  localparam int S2_EXT_FEAT = 3;
  localparam int S2_SKIP_IDL = 2;
  localparam int S2_RCN_LSB  = 0;
  // Writable bits and reset values; reserved bits read zero.
  localparam logic [7:0] S1_WMASK = 8'hDF;
  localparam logic [7:0] S2_WMASK = 8'h8F;
  localparam logic [7:0] S1_RESET = 8'h06;
  localparam logic [7:0] S2_RESET = 8'h00;
  // Interrupt status bit positions.
  localparam int IRQ_EXCESS = 0;
  localparam int IRQ_RECONF = 1;
  localparam int IRQ_INIT   = 2;
  localparam int IRQ_W      = 3;
  // Refusal limits.
  localparam logic [7:0] LIMIT_SHORT = 8'h04;
  localparam logic [7:0] LIMIT_LONG  = 8'h80;
  // Rate divisor is the base shifted left by the prescaler code.
  localparam int RATE_BASE = 8;
  // Reconfiguration timeouts in milliseconds.
  localparam int RECON_MS_0 = 6720;
  localparam int RECON_MS_1 = 1680;
  localparam int RECON_MS_2 = 840;
  localparam int RECON_MS_3 = 420;
  // Clock rate and one millisecond in cycles.
  localparam int CLK_HZ = 50000000;
  localparam int MS_CYC = CLK_HZ / 1000;
endpackage

// ---- verif/nsr_props.sv ----
// Checker of port relations of the setup register bank.
`timescale 1ns/10ps
module nsr_props #(
  parameter int MS_CYC = 10  // Cycles per millisecond.
) (
  input wire logic       clk_i,                 // Clock.
  input wire logic       rst_i,                 // Reset.
  input wire logic       wb_ack_o,              // Bus acknowledge.
  input wire logic       line_pulse_out_o,      // Pulse value.
  input wire logic       line_pulse_oe_n_o,     // Pulse enable.
  input wire logic       refusal_i,             // Refusal pulse.
  input wire logic       excess_refusal_flag_o, // Excess flag.
  input wire logic       pkt_valid_i,           // Packet valid.
  input wire logic [7:0] pkt_dest_i,            // Destination.
  input wire logic [7:0] node_id_i,             // Own node.
  input wire logic       pkt_accept_o,          // Accept.
  input wire logic       pkt_ack_o,             // Acknowledge.
  input wire logic       token_pass_o,          // Token passing.
  input wire logic       listen_only_o,         // Listen-only.
  input wire logic       rate_tick_o,           // Rate tick.
  input wire logic       fast_read_timing_o     // Fast read.
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_drv; line_pulse_out_o |-> !line_pulse_oe_n_o; endproperty
  a_drv: assert property (p_drv) else $error("pulse high undriven");
  property p_acc; pkt_valid_i && pkt_dest_i == node_id_i |=> pkt_accept_o; endproperty
  a_acc: assert property (p_acc) else $error("own packet dropped");
  property p_ack; pkt_ack_o |-> $past(pkt_valid_i) && $past(pkt_dest_i) == $past(node_id_i);
  endproperty
  a_ack: assert property (p_ack) else $error("ack without match");
  property p_lst; listen_only_o |-> !token_pass_o; endproperty
  a_lst: assert property (p_lst) else $error("listen with token");
  property p_rate; rate_tick_o |=> !rate_tick_o [*7]; endproperty
  a_rate: assert property (p_rate) else $error("rate tick too soon");
  property p_flag; $rose(excess_refusal_flag_o) |-> $past(refusal_i) || $past(refusal_i, 2);
  endproperty
  a_flag: assert property (p_flag) else $error("flag without refusal");
  property p_frt; !$stable(fast_read_timing_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2);
  endproperty
  a_frt: assert property (p_frt) else $error("fast read changed alone");
  property p_wbk; wb_ack_o |=> !wb_ack_o; endproperty
  a_wbk: assert property (p_wbk) else $error("ack longer than a cycle");
endmodule

bind nsr_top nsr_props #(.MS_CYC(MS_CYC)) u_nsr_props (.*);

// ---- verif/nsr_net.sv ----
// Model of the other nodes: packet headers and refused enquiries.
`timescale 1ns/10ps
module nsr_net (
  input  wire logic clk_i,       // Clock.
  output logic       pkt_valid_o, // Header pulse.
  output logic [7:0] pkt_dest_o,  // Destination.
  output logic       refusal_o    // Refused enquiry.
);
  initial
  begin
    pkt_valid_o = 1'b0;
    pkt_dest_o = 8'h00;
    refusal_o = 1'b0;
  end
  // One header; the destination shows its inverse once released.
  task automatic send(input logic [7:0] d);
    @(posedge clk_i);
    pkt_valid_o <= 1'b1;
    pkt_dest_o <= d;
    @(posedge clk_i);
    pkt_valid_o <= 1'b0;
    pkt_dest_o <= ~d;
  endtask
  // Back-to-back refusals, one per cycle.
  task automatic refuse(input int n);
    repeat (n) @(posedge clk_i) refusal_o <= 1'b1;
    @(posedge clk_i) refusal_o <= 1'b0;
  endtask
endmodule

// ---- verif/nsr_top_tb.sv ----
// Self-checking bench of the setup register bank.
`timescale 1ns/10ps
module nsr_top_tb;
  localparam int MSC = 2;  // Shortened millisecond, so that every timeout code fits the run.
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, pd = 1'b0;
  logic ir = 1'b0, idl = 1'b0, rr = 1'b0, tx = 1'b1;
  logic [7:0] adr = 8'h00, nid = 8'h00, pdst;
  logic [3:0] sel = 4'h0;
  logic [31:0] wd = 32'h0, rdat, dat, st = 32'h3A, rdo;
  logic ack, irq, lpo, lpe, exf, pv, acc, pka, tok, lst, rtk, atk, ist, rto, frt, xf, rf;
  int num_errors = 0, samples_checked = 0, g, exp_cyc;
  nsr_top #(.MS_CYC(MSC)) u_nsr_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdo), .wb_ack_o(ack),
    .irq_o(irq), .pulse_data_i(pd), .line_pulse_out_o(lpo), .line_pulse_oe_n_o(lpe),
    .refusal_i(rf), .excess_refusal_flag_o(exf), .pkt_valid_i(pv), .pkt_dest_i(pdst),
    .node_id_i(nid), .tx_enable_i(tx), .pkt_accept_o(acc), .pkt_ack_o(pka),
    .token_pass_o(tok), .listen_only_o(lst), .rate_tick_o(rtk), .arb_tick_o(atk),
    .init_req_i(ir), .line_idle_i(idl), .init_start_o(ist), .recon_restart_i(rr),
    .recon_timeout_o(rto), .fast_read_timing_o(frt), .extended_features_o(xf));
  nsr_net u_nsr_net (.clk_i(clk_i), .pkt_valid_o(pv), .pkt_dest_o(pdst), .refusal_o(rf));
  // Free-running 50 MHz clock.
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  // Xorshift source for stimulus values.
  function automatic logic [31:0] xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask
  // One classic bus cycle, held until acknowledge is sampled.
  task automatic wbt(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= 4'hF;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = rdo;
    cyc <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    if (n >= 50) chk(0, 1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wbt(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic cnt(input int n);
    g = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      if (ist === 1'b1) g++;
    end
  endtask
  // Edges between two rate ticks.
  task automatic gap();
    int n;
    n = 0;
    while (rtk !== 1'b1 && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    g = 0;
    do
    begin
      @(posedge clk_i);
      g++;
    end while (rtk !== 1'b1 && g < 300);
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard.
  initial
  begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    end_of_test();
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(nsr_pkg::ADDR_SETUP1, 32'h06);
    rdc(nsr_pkg::ADDR_SETUP2, 32'h00);
    rdc(nsr_pkg::ADDR_STATUS, 32'h00);
    wbt(1'b1, nsr_pkg::ADDR_SETUP1, 32'hFF);
    rdc(nsr_pkg::ADDR_SETUP1, 32'hDF);
    // Timeout code stays at the longest, so no timeout event disturbs the status checks.
    wbt(1'b1, nsr_pkg::ADDR_SETUP2, 32'hFC);
    rdc(nsr_pkg::ADDR_SETUP2, 32'h8C);
    chk(frt, 1);
    chk(xf, 1);
    wbt(1'b1, 8'h14, 32'hFF);
    rdc(8'h14, 32'h00);
    // Line pulse driver, open drain then push-pull.
    for (int m = 0; m < 2; m++)
    begin
      wbt(1'b1, nsr_pkg::ADDR_SETUP1, m ? 32'h86 : 32'h06);
      repeat (6)
      begin
        dat = xs();
        @(posedge clk_i) pd <= dat[0];
        w(2);
        chk(lpo, m ? pd : 1'b0);
        chk(lpe, m ? 1'b0 : pd);
      end
    end
    // Rate divisor and arbitration halving.
    for (int c = 3; c < 5; c++)
    begin
      wbt(1'b1, nsr_pkg::ADDR_SETUP1, (c << 1) | (c - 3));
      gap();
      gap();
      chk(g, c == 3 ? 64 : 128);
      g = 0;
      repeat (16) @(posedge clk_i) if (atk === 1'b1) g++;
      chk(g, c == 3 ? 16 : 8);
    end
    // Refusal limits, interrupt mask and clearing.
    wbt(1'b1, nsr_pkg::ADDR_MASK, 32'h01);
    for (int k = 0; k < 2; k++)
    begin
      wbt(1'b1, nsr_pkg::ADDR_SETUP1, k ? 32'h06 : 32'h46);
      u_nsr_net.refuse(k ? 127 : 3);
      w(3);
      chk(exf, 0);
      u_nsr_net.refuse(1);
      w(3);
      chk(exf, 1);
      chk(irq, k ? 0 : 1);
      rdc(nsr_pkg::ADDR_STATUS, 32'h01);
      wbt(1'b1, nsr_pkg::ADDR_STATUS, 32'h01);
      wbt(1'b1, nsr_pkg::ADDR_MASK, 32'h00);
      w(2);
      chk(exf, 0);
      chk(irq, 0);
    end
    // Random packets against promiscuous and transmitter settings.
    for (int i = 0; i < 8; i++)
    begin
      dat = xs();
      wbt(1'b1, nsr_pkg::ADDR_SETUP1, dat[0] ? 32'h16 : 32'h06);
      @(posedge clk_i);
      tx <= dat[1];
      nid <= dat[15:8];
      u_nsr_net.send(dat[2] ? dat[15:8] : dat[23:16]);
      @(posedge clk_i);
      chk(acc, dat[0] | dat[2] | dat[15:8] == dat[23:16]);
      chk(pka, dat[2] | dat[15:8] == dat[23:16]);
      chk(lst, dat[0] & ~dat[1]);
      chk(tok, dat[1]);
    end
    // RAM initialization waits for idle line unless skipped.
    for (int s = 0; s < 2; s++)
    begin
      wbt(1'b1, nsr_pkg::ADDR_SETUP2, s ? 32'h04 : 32'h00);
      @(posedge clk_i);
      idl <= 1'b0;
      ir <= 1'b1;
      @(posedge clk_i);
      ir <= 1'b0;
      cnt(12);
      chk(g, s);
      idl <= 1'b1;
      cnt(12);
      chk(g, 1 - s);
    end
    // Reconfiguration timeouts of all four codes, in shortened milliseconds.
    for (int r = 0; r < 4; r++)
    begin
      wbt(1'b1, nsr_pkg::ADDR_SETUP2, r);
      @(posedge clk_i);
      rr <= 1'b1;
      @(posedge clk_i);
      rr <= 1'b0;
      g = 0;
      exp_cyc = (r == 0 ? nsr_pkg::RECON_MS_0 : nsr_pkg::RECON_MS_1 >> (r - 1)) * MSC;
      while (rto !== 1'b1 && g < 15000) @(posedge clk_i) g++;
      chk(g >= exp_cyc - 4 && g <= exp_cyc + 4, 1);
    end
    // Init and timeout events stay pending and raise the interrupt once unmasked.
    rdc(nsr_pkg::ADDR_STATUS, (1 << nsr_pkg::IRQ_RECONF) | (1 << nsr_pkg::IRQ_INIT));
    wbt(1'b1, nsr_pkg::ADDR_MASK, 32'h06);
    w(2);
    chk(irq, 1);
    end_of_test();
  end
endmodule
